// ==== hdl/sysctl_error_debug_regs.sv ====
/*
  System-control error/debug register slice: diagnostic link address,
  watch pair with watch detection, extended page context, compatibility
  error registers, cache tag staging pair, error resume PC, plus the
  translation buffer array and mode-checked lookup.
  Assumes the pipeline drives the coprocessor move ports and exception
  commits on ref_clk; the short-ISA pin is asynchronous.

*/
`timescale 1ns/1ps
`default_nettype none
module sysctl_error_debug_regs
  import sysctl_pkg::*;
#(
  parameter int TLB_DEPTH = sysctl_pkg::TLB_ENTRIES
) (
  input  wire logic                            ref_clk,
  input  wire logic                            rst_n,
  input  wire logic                            ce,
  // coprocessor moves
  input  wire logic                            cop_wr,
  input  wire logic [4:0]                      cop_wr_num,
  input  wire logic [sysctl_pkg::DATA_W-1:0]   cop_wr_data,
  input  wire logic [4:0]                      cop_rd_num,
  output logic      [sysctl_pkg::DATA_W-1:0]   cop_rd_data,
  // cache maintenance tag load
  input  wire logic                            cache_tag_wr,
  input  wire logic [sysctl_pkg::WORD_W-1:0]   cache_tag_low_in,
  input  wire logic [sysctl_pkg::WORD_W-1:0]   cache_tag_high_in,
  // memory references for watch
  input  wire logic                            mem_valid,
  input  wire logic                            mem_load,
  input  wire logic                            mem_store,
  input  wire logic [sysctl_pkg::PADDR_W-1:0]  mem_paddr,
  output logic                                 watch_exception,
  // exception commit
  input  wire logic                            exc_commit,
  input  wire sysctl_pkg::exc_kind_e           exc_kind,
  input  wire logic [sysctl_pkg::DATA_W-1:0]   exc_vaddr,
  input  wire logic [sysctl_pkg::DATA_W-1:0]   exc_inst_pc,
  input  wire logic [sysctl_pkg::DATA_W-1:0]   exc_prev_pc,
  input  wire logic                            exc_in_delay_slot,
  input  wire logic                            exc_after_extend,
  input  wire logic                            exc_isa16_mode,
  input  wire logic                            error_level_flag,
  output logic                                 branch_delay_flag,
  output logic      [sysctl_pkg::DATA_W-1:0]   bad_virtual_address,
  // short-ISA strap pin
  input  wire logic                            short_isa_enable_pin,
  output logic                                 short_isa_enabled,
  // translation buffer write and lookup
  input  wire logic                            tlb_wr,
  input  wire logic [sysctl_pkg::TLB_IDX_W-1:0] tlb_wr_idx,
  input  wire logic [sysctl_pkg::DATA_W-1:0]   tlb_wr_vaddr,
  input  wire logic [sysctl_pkg::TLB_PAY_W-1:0] tlb_wr_payload,
  input  wire logic [sysctl_pkg::DATA_W-1:0]   lookup_vaddr,
  input  wire sysctl_pkg::op_mode_e            op_mode,
  input  wire logic                            addr64_mode,
  output logic                                 tlb_hit,
  output logic      [sysctl_pkg::TLB_PAY_W-1:0] tlb_payload,
  output logic                                 address_error
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic                     pin_meta;
    logic                     pin_sync;
    logic [1:0]               strap_count;
    logic                     strap_taken;
    logic                     isa16_en;
    logic [WORD_W-1:0]        link_address_diag;
    logic [WORD_W-1:0]        watch_addr_low;
    logic [WORD_W-1:0]        watch_addr_high;
    logic [CTX_BASE_W-1:0]    page_table_base;
    logic [CTX_SPACE_W-1:0]   space_type;
    logic [CTX_PAGE_W-1:0]    failed_page_pair;
    logic [DATA_W-1:0]        bad_va;
    logic [WORD_W-1:0]        parity_error_compat;
    logic [WORD_W-1:0]        cache_error_compat;
    logic [WORD_W-1:0]        cache_tag_low;
    logic [WORD_W-1:0]        cache_tag_high;
    logic [DATA_W-1:0]        error_resume_pc;
    logic                     bd;
    logic [DATA_W-1:0]        rd_data;
    logic                     watch_exc;
    logic                     hit;
    logic [TLB_PAY_W-1:0]     payload;
    logic                     addr_err;
  } regs_s;

  regs_s                  state;
  regs_s                  next_state;

  logic [DATA_W-1:0]      fmt_pc;
  logic                   fmt_bd;
  logic [DATA_W-1:0]      eff_vaddr;
  logic [DATA_W-1:0]      eff_wr_vaddr;
  logic [TLB_KEY_W-1:0]   lookup_key;
  logic [TLB_KEY_W-1:0]   wr_key;
  logic                   lut_hit;
  logic [TLB_PAY_W-1:0]   lut_payload;
  logic                   watch_match;
  logic                   watch_kind_ok;
  logic [CTX_SPACE_W-1:0] lookup_space;
  logic                   space_denied;
  logic [DATA_W-1:0]      extended_page_context_view;
  logic                   move_to_coprocessor;
  logic                   err_capture;
  logic                   miss_capture;

  // ==========================================================================
  // resume address formatting
  error_pc_format u_error_pc_format (
    .isa16_en      (state.isa16_en),
    .isa16_mode    (exc_isa16_mode),
    .in_delay_slot (exc_in_delay_slot),
    .after_extend  (exc_after_extend),
    .inst_pc       (exc_inst_pc),
    .prev_pc       (exc_prev_pc),
    .resume_pc     (fmt_pc),
    .bd            (fmt_bd)
  );

  // ==========================================================================
  // addressing mode: 32-bit mode sees a sign-extended address
  localparam int HALF_W = DATA_W / 2;

  assign eff_vaddr    = addr64_mode ? lookup_vaddr
                                    : {{HALF_W{lookup_vaddr[VA_SIGN_BIT]}},
                                       lookup_vaddr[HALF_W-1:0]};
  assign eff_wr_vaddr = addr64_mode ? tlb_wr_vaddr
                                    : {{HALF_W{tlb_wr_vaddr[VA_SIGN_BIT]}},
                                       tlb_wr_vaddr[HALF_W-1:0]};
  assign lookup_space = eff_vaddr[VA_SPACE_MSB:VA_SPACE_LSB];
  assign lookup_key   = {lookup_space, eff_vaddr[VA_PAGE_MSB:VA_PAGE_LSB]};
  assign wr_key       = {eff_wr_vaddr[VA_SPACE_MSB:VA_SPACE_LSB],
                         eff_wr_vaddr[VA_PAGE_MSB:VA_PAGE_LSB]};

  // user reaches only user space, supervisor not kernel space
  always_comb begin
    space_denied = 1'b0;
    unique case (op_mode)
      MODE_USER:   space_denied = (lookup_space != SPACE_USER);
      MODE_SUPER:  space_denied = (lookup_space == SPACE_KERN);
      MODE_KERNEL: space_denied = 1'b0;
      default:     space_denied = 1'b1;
    endcase
  end

  // ==========================================================================
  // translation buffer
  tlb_pair_array #(
    .ENTRIES (TLB_DEPTH),
    .IDX_W   (TLB_IDX_W),
    .KEY_W   (TLB_KEY_W),
    .PAY_W   (TLB_PAY_W)
  ) u_tlb_pair_array (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .wr_en       (tlb_wr),
    .wr_idx      (tlb_wr_idx),
    .wr_key      (wr_key),
    .wr_payload  (tlb_wr_payload),
    .lookup_key  (lookup_key),
    .hit         (lut_hit),
    .hit_payload (lut_payload)
  );

  // ==========================================================================
  // watch compare
  // the physical address is 32 bits wide, so a high part with non-zero bits [3:0] never matches; bits above 3 are ignored
  assign watch_match   = (state.watch_addr_low[WORD_W-1:WATCH_ADDR_LSB] ==
                          mem_paddr[PADDR_W-1:WATCH_ADDR_LSB]) &&
                         (state.watch_addr_high[WATCH_HIGH_W-1:0] == '0);
  assign watch_kind_ok = (mem_load  && state.watch_addr_low[WATCH_LD_BIT]) ||
                         (mem_store && state.watch_addr_low[WATCH_ST_BIT]);

  // ==========================================================================
  // register views and capture conditions
  assign extended_page_context_view = {state.page_table_base, state.space_type,
                          state.failed_page_pair, CTX_ZERO};

  assign move_to_coprocessor = cop_wr;
  assign miss_capture = exc_commit && (exc_kind == EXC_TLB_MISS);
  // further errors while the error level is up must not lose the first address
  assign err_capture  = exc_commit && (exc_kind == EXC_ERROR) && !error_level_flag;

  // ==========================================================================
  // next state
  always_comb begin
    next_state = state;

    // strap: two-flop synchroniser, then one capture after it has settled
    next_state.pin_meta = short_isa_enable_pin;
    next_state.pin_sync = state.pin_meta;
    if (!state.strap_taken) begin
      if (state.strap_count == STRAP_SETTLE) begin
        next_state.isa16_en    = state.pin_sync;
        next_state.strap_taken = 1'b1;
      end else begin
        next_state.strap_count = state.strap_count + 2'h1;
      end
    end

    // software moves
    if (move_to_coprocessor) begin
      unique case (cop_wr_num)
        REG_LINK_ADDR:  next_state.link_address_diag = cop_wr_data[WORD_W-1:0];
        REG_WATCH_LOW:  next_state.watch_addr_low    = cop_wr_data[WORD_W-1:0];
        REG_WATCH_HIGH: next_state.watch_addr_high   = cop_wr_data[WORD_W-1:0];
        REG_EXTENDED_PAGE_CONTEXT:   next_state.page_table_base   =
                          cop_wr_data[DATA_W-1:CTX_BASE_LSB];
        REG_PARITY:     next_state.parity_error_compat = cop_wr_data[WORD_W-1:0];
        REG_CACHE_ERR:  next_state.cache_error_compat  = cop_wr_data[WORD_W-1:0];
        REG_TAG_LOW:    next_state.cache_tag_low     = cop_wr_data[WORD_W-1:0];
        REG_TAG_HIGH:   next_state.cache_tag_high    = cop_wr_data[WORD_W-1:0];
        REG_ERROR_PC:   next_state.error_resume_pc   = cop_wr_data;
        default: begin
        end
      endcase
    end

    // cache maintenance load wins over a move in the same cycle
    if (cache_tag_wr) begin
      next_state.cache_tag_low  = cache_tag_low_in;
      next_state.cache_tag_high = cache_tag_high_in;
    end

    // translation miss: space, failed page and bad address only, base is left alone
    if (miss_capture) begin
      next_state.space_type       = exc_vaddr[VA_SPACE_MSB:VA_SPACE_LSB];
      next_state.failed_page_pair = exc_vaddr[VA_PAGE_MSB:VA_PAGE_LSB];
      next_state.bad_va           = exc_vaddr;
    end

    // error exception: hardware capture beats a move in the same cycle
    if (err_capture) begin
      next_state.error_resume_pc = fmt_pc;
      next_state.bd              = fmt_bd;
    end

    // registered read port, unmapped numbers read zero
    unique case (cop_rd_num)
      REG_LINK_ADDR:  next_state.rd_data = {ZERO_WORD, state.link_address_diag};
      REG_WATCH_LOW:  next_state.rd_data = {ZERO_WORD, state.watch_addr_low};
      REG_WATCH_HIGH: next_state.rd_data = {ZERO_WORD, state.watch_addr_high};
      REG_EXTENDED_PAGE_CONTEXT:   next_state.rd_data = extended_page_context_view;
      REG_PARITY:     next_state.rd_data = {ZERO_WORD, state.parity_error_compat};
      REG_CACHE_ERR:  next_state.rd_data = {ZERO_WORD, state.cache_error_compat};
      REG_TAG_LOW:    next_state.rd_data = {ZERO_WORD, state.cache_tag_low};
      REG_TAG_HIGH:   next_state.rd_data = {ZERO_WORD, state.cache_tag_high};
      REG_ERROR_PC:   next_state.rd_data = state.error_resume_pc;
      default:        next_state.rd_data = ZERO_DWORD;
    endcase

    // watch and lookup results, one cycle behind their inputs
    next_state.watch_exc = mem_valid && watch_kind_ok && watch_match;
    next_state.hit       = lut_hit && !space_denied;
    next_state.payload   = lut_payload;
    next_state.addr_err  = space_denied;
  end

  // ==========================================================================
  // registers
  // data registers are undefined to software after reset; zero keeps sim clean
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // outputs
  assign cop_rd_data         = state.rd_data;
  assign watch_exception     = state.watch_exc;
  assign branch_delay_flag   = state.bd;
  assign bad_virtual_address = state.bad_va;
  assign short_isa_enabled   = state.isa16_en;
  assign tlb_hit             = state.hit;
  assign tlb_payload         = state.payload;
  assign address_error       = state.addr_err;

endmodule
`default_nettype wire

// ==== hdl/sysctl_pkg.sv ====
/*
  Shared constants of the register slice: register numbers, field
  layouts, buffer sizing and exception kinds.
  Assumes it is compiled before every design file that imports it.
*/
package sysctl_pkg;

  // ==========================================================================
  // coprocessor register numbers
  localparam logic [4:0] REG_LINK_ADDR   = 5'h11;
  localparam logic [4:0] REG_WATCH_LOW   = 5'h12;
  localparam logic [4:0] REG_WATCH_HIGH  = 5'h13;
  localparam logic [4:0] REG_EXTENDED_PAGE_CONTEXT    = 5'h14;
  localparam logic [4:0] REG_PARITY      = 5'h1a;
  localparam logic [4:0] REG_CACHE_ERR   = 5'h1b;
  localparam logic [4:0] REG_TAG_LOW     = 5'h1c;
  localparam logic [4:0] REG_TAG_HIGH    = 5'h1d;
  localparam logic [4:0] REG_ERROR_PC    = 5'h1e;

  // ==========================================================================
  // widths
  localparam int DATA_W   = 64;
  localparam int WORD_W   = 32;
  localparam int PADDR_W  = 32;

  // ==========================================================================
  // extended context layout: base | space | failed page | zero
  localparam int CTX_ZERO_W     = 3;
  localparam int CTX_PAGE_W     = 29;
  localparam int CTX_SPACE_W    = 2;
  localparam int CTX_BASE_W     = 30;
  localparam int CTX_BASE_LSB   = 34;
  localparam int VA_PAGE_LSB    = 11;
  localparam int VA_PAGE_MSB    = 39;
  localparam int VA_SPACE_LSB   = 62;
  localparam int VA_SPACE_MSB   = 63;
  localparam int VA_SIGN_BIT    = 31;
  localparam logic [CTX_ZERO_W-1:0]  CTX_ZERO    = 3'h0;
  localparam logic [CTX_SPACE_W-1:0] SPACE_USER  = 2'h0;
  localparam logic [CTX_SPACE_W-1:0] SPACE_SUPER = 2'h1;
  localparam logic [CTX_SPACE_W-1:0] SPACE_KERN  = 2'h3;

  // ==========================================================================
  // watch layout: low holds paddr[31:3], load enable, store enable
  localparam int WATCH_ADDR_LSB = 3;
  localparam int WATCH_LD_BIT   = 1;
  localparam int WATCH_ST_BIT   = 0;
  localparam int WATCH_HIGH_W   = 4;

  // ==========================================================================
  // translation buffer
  localparam int TLB_ENTRIES = 32;
  localparam int TLB_IDX_W   = 5;
  localparam int TLB_KEY_W   = CTX_SPACE_W + CTX_PAGE_W;
  localparam int TLB_PAY_W   = 32;

  // ==========================================================================
  // zero fill values for reads and strap settle count
  localparam logic [WORD_W-1:0] ZERO_WORD   = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ZERO_DWORD  = 64'h0000_0000_0000_0000;
  localparam logic [1:0]        STRAP_SETTLE = 2'h2;

  typedef enum logic [1:0] {EXC_NONE, EXC_TLB_MISS, EXC_ERROR, EXC_OTHER} exc_kind_e;
  typedef enum logic [1:0] {MODE_USER, MODE_SUPER, MODE_KERNEL} op_mode_e;

endpackage

// ==== hdl/tlb_pair_array.sv ====
/*
  Fully associative pair translation buffer: written by index, looked up
  by key combinationally.
  Assumes the caller registers the lookup result.
*/
`timescale 1ns/1ps
`default_nettype none
module tlb_pair_array
  import sysctl_pkg::*;
#(
  parameter int ENTRIES = sysctl_pkg::TLB_ENTRIES,
  parameter int IDX_W   = sysctl_pkg::TLB_IDX_W,
  parameter int KEY_W   = sysctl_pkg::TLB_KEY_W,
  parameter int PAY_W   = sysctl_pkg::TLB_PAY_W
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [KEY_W-1:0] wr_key,
  input  wire logic [PAY_W-1:0] wr_payload,
  input  wire logic [KEY_W-1:0] lookup_key,
  output logic                  hit,
  output logic      [PAY_W-1:0] hit_payload
);

  typedef struct packed {
    logic [ENTRIES-1:0]            valid;
    logic [ENTRIES-1:0][KEY_W-1:0] key;
    logic [ENTRIES-1:0][PAY_W-1:0] pay;
  } tlb_s;

  tlb_s             state;
  tlb_s             next_state;
  logic [ENTRIES:0] any_chain;
  logic [ENTRIES:0][PAY_W-1:0] pay_chain;

  assign any_chain[0] = 1'b0;
  assign pay_chain[0] = '0;

  // ==========================================================================
  // per-entry compare; keys are unique by software so an OR reduction is enough
  for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
    logic match;
    assign match            = state.valid[i] && (state.key[i] == lookup_key);
    assign any_chain[i+1]   = any_chain[i] | match;
    assign pay_chain[i+1]   = pay_chain[i] | (match ? state.pay[i] : '0);
  end

  assign hit         = any_chain[ENTRIES];
  assign hit_payload = pay_chain[ENTRIES];

  always_comb begin
    next_state = state;
    if (wr_en) begin
      next_state.valid[wr_idx] = 1'b1;
      next_state.key[wr_idx]   = wr_key;
      next_state.pay[wr_idx]   = wr_payload;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end

endmodule
`default_nettype wire

// ==== hdl/error_pc_format.sv ====
/*
  Error resume address and delay flag former, purely combinational.
  Assumes the pipeline gives the faulting and preceding addresses.
*/
`timescale 1ns/1ps
`default_nettype none
module error_pc_format
  import sysctl_pkg::*;
(
  input  wire logic              isa16_en,
  input  wire logic              isa16_mode,
  input  wire logic              in_delay_slot,
  input  wire logic              after_extend,
  input  wire logic [DATA_W-1:0] inst_pc,
  input  wire logic [DATA_W-1:0] prev_pc,
  output logic      [DATA_W-1:0] resume_pc,
  output logic                   bd
);

  logic             use_prev;
  logic [DATA_W-1:0] base_pc;

  // an extend prefix only exists while short instructions run
  assign use_prev = in_delay_slot || (isa16_en && isa16_mode && after_extend);
  // never point into a delay slot or past a prefix
  assign base_pc  = use_prev ? prev_pc : inst_pc;

  always_comb begin
    resume_pc = base_pc;
    bd        = use_prev;
    if (isa16_en) begin
      // mode sits in bit 0 so a return restores it
      resume_pc = {base_pc[DATA_W-1:1], isa16_mode};
    end
  end

endmodule
`default_nettype wire

// ==== sim/error_debug_monitor.sv ====
/*
  Checker on the register slice top ports.
  Assumes the package is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module error_debug_monitor
  import sysctl_pkg::*;
(
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic                  ce,
  input wire logic                  mem_valid,
  input wire logic                  mem_load,
  input wire logic                  mem_store,
  input wire logic                  watch_exception,
  input wire logic                  exc_commit,
  input wire sysctl_pkg::exc_kind_e exc_kind,
  input wire logic [63:0]           exc_vaddr,
  input wire logic                  exc_in_delay_slot,
  input wire logic                  error_level_flag,
  input wire logic                  branch_delay_flag,
  input wire logic [63:0]           bad_virtual_address,
  input wire logic [4:0]            cop_rd_num,
  input wire logic [63:0]           cop_rd_data,
  input wire logic                  tlb_hit,
  input wire logic                  address_error
);
  // ==========================================================================
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  watch_cause_a:
    assert property (watch_exception |-> $past(ce && mem_valid && (mem_load || mem_store)))
    else $error("stray watch");
  miss_capture_a:
    assert property (ce && exc_commit && exc_kind == EXC_TLB_MISS
      |=> bad_virtual_address == $past(exc_vaddr)) else $error("miss not captured");
  miss_hold_a:
    assert property (ce && !(exc_commit && exc_kind == EXC_TLB_MISS)
      |=> $stable(bad_virtual_address)) else $error("bad address moved");
  erl_freeze_a:
    assert property (ce && exc_commit && error_level_flag |=> $stable(branch_delay_flag))
    else $error("flag moved at error level");
  slot_flag_a:
    assert property (ce && exc_commit && exc_kind == EXC_ERROR && !error_level_flag
      && exc_in_delay_slot |=> branch_delay_flag) else $error("delay flag not set");
  ctx_zero_a:
    assert property (ce && cop_rd_num == REG_EXTENDED_PAGE_CONTEXT |=> cop_rd_data[2:0] == 3'h0)
    else $error("context low bits nonzero");
  tag_width_a:
    assert property (ce && (cop_rd_num == REG_TAG_LOW || cop_rd_num == REG_TAG_HIGH)
      |=> cop_rd_data[63:32] == 32'h0000_0000) else $error("tag high half set");
  mode_block_a:
    assert property (address_error |-> !tlb_hit) else $error("hit despite mode error");
endmodule
`default_nettype wire

// ==== sim/strap_source.sv ====
/*
  Board strap model: holds the short-ISA pin level.
  Assumes the bench changes the level only while reset is held.
*/
`timescale 1ns/1ps
`default_nettype none
module strap_source (
  input  wire logic level,
  output logic      short_isa_enable_pin
);
  // ==========================================================================
  // strap is static after reset, so a follower is enough
  assign short_isa_enable_pin = level;
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
/*
  Self-checking bench for the register slice.
  Assumes all other files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sysctl_pkg::*;
  // ==========================================================================
  // signals
  logic ref_clk = '0, rst_n = '0, ce = 1'h1, cop_wr = '0, cache_tag_wr = '0, mem_valid = '0;
  logic mem_load = '0, mem_store = '0, exc_commit = '0, exc_in_delay_slot = '0, tlb_wr = '0;
  logic exc_after_extend = '0, exc_isa16_mode = '0, error_level_flag = '0, level = '0;
  logic addr64_mode = 1'h1, watch_exception, branch_delay_flag, short_isa_enabled;
  logic tlb_hit, address_error;
  wire  short_isa_enable_pin;
  logic [4:0]  cop_wr_num = '0, cop_rd_num = '0, tlb_wr_idx = '0;
  logic [31:0] cache_tag_low_in = '0, cache_tag_high_in = '0, mem_paddr = '0;
  logic [31:0] tlb_wr_payload = '0, tlb_payload;
  logic [63:0] cop_wr_data = '0, exc_vaddr = '0, tlb_wr_vaddr = '0, lookup_vaddr = '0;
  logic [63:0] exc_inst_pc = 64'h8000_0104, exc_prev_pc = 64'h8000_0100;
  logic [63:0] cop_rd_data, bad_virtual_address;
  exc_kind_e exc_kind = EXC_NONE;
  op_mode_e  op_mode = MODE_KERNEL;
  int errors = 0, checks_done = 0;
  always #5 ref_clk = ~ref_clk;
  strap_source u_strap (.level, .short_isa_enable_pin);
  sysctl_error_debug_regs #(.TLB_DEPTH(32)) DUT (.ref_clk, .rst_n, .ce, .cop_wr, .cop_wr_num,
    .cop_wr_data, .cop_rd_num, .cop_rd_data, .cache_tag_wr, .cache_tag_low_in,
    .cache_tag_high_in, .mem_valid, .mem_load, .mem_store, .mem_paddr, .watch_exception,
    .exc_commit, .exc_kind, .exc_vaddr, .exc_inst_pc, .exc_prev_pc, .exc_in_delay_slot,
    .exc_after_extend, .exc_isa16_mode, .error_level_flag, .branch_delay_flag,
    .bad_virtual_address, .short_isa_enable_pin, .short_isa_enabled, .tlb_wr, .tlb_wr_idx,
    .tlb_wr_vaddr, .tlb_wr_payload, .lookup_vaddr, .op_mode, .addr64_mode, .tlb_hit,
    .tlb_payload, .address_error);
  // ==========================================================================
  // shared tasks; all drive at the falling edge
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] num, input logic [63:0] data);
    @(negedge ref_clk);
    cop_wr = 1'h1;
    cop_wr_num = num;
    cop_wr_data = data;
    @(negedge ref_clk);
    cop_wr = 1'h0;
  endtask
  task automatic rd(input logic [4:0] num, input logic [63:0] exp);
    cop_rd_num = num;
    @(negedge ref_clk);
    chk(cop_rd_data, exp);
  endtask
  task automatic do_reset(input logic pin);
    rst_n = 1'h0;
    level = pin;
    repeat (6) @(negedge ref_clk);
    rst_n = 1'h1;
    repeat (4) @(negedge ref_clk);
    chk(short_isa_enabled, pin);
  endtask
  task automatic mref(input logic ld, input logic st, input logic [31:0] pa, input logic w);
    @(negedge ref_clk);
    {mem_valid, mem_load, mem_store, mem_paddr} = {1'h1, ld, st, pa};
    @(negedge ref_clk);
    mem_valid = 1'h0;
    chk(watch_exception, w);
  endtask
  // flags are {delay slot, after extend, isa16 mode, error level}
  task automatic commit(input exc_kind_e k, input logic [63:0] va, input logic [3:0] f);
    @(negedge ref_clk);
    {exc_commit, exc_kind, exc_vaddr} = {1'h1, k, va};
    {exc_in_delay_slot, exc_after_extend, exc_isa16_mode, error_level_flag} = f;
    @(negedge ref_clk);
    exc_commit = 1'h0;
  endtask
  task automatic ep(input logic [3:0] f, input logic [63:0] pc, input logic bd);
    commit(EXC_ERROR, 64'h0, f);
    chk(branch_delay_flag, bd);
    rd(REG_ERROR_PC, pc);
  endtask
  task automatic look(input op_mode_e m, input logic [63:0] va, input logic [1:0] e);
    op_mode = m;
    lookup_vaddr = va;
    @(negedge ref_clk);
    chk({address_error, tlb_hit}, e);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs();
    logic [4:0] nums [4] = '{REG_LINK_ADDR, REG_PARITY, REG_CACHE_ERR, REG_TAG_HIGH};
    foreach (nums[i]) begin
      wr(nums[i], 64'hC3C3_0000 + nums[i]);
      rd(nums[i], 64'hC3C3_0000 + nums[i]);
    end
    wr(REG_TAG_LOW, 64'hFFFF_FFFF_A5A5_5A5A);
    rd(REG_TAG_LOW, 64'hA5A5_5A5A);
    {cache_tag_wr, cache_tag_low_in, cache_tag_high_in} = {1'h1, 64'h1234_5678_9ABC_DEF0};
    {cop_wr, cop_wr_num, cop_wr_data} = {1'h1, REG_TAG_HIGH, 64'h0};
    @(negedge ref_clk);
    {cache_tag_wr, cop_wr} = 2'h0;
    rd(REG_TAG_LOW, 64'h1234_5678);
    rd(REG_TAG_HIGH, 64'h9ABC_DEF0);
    rd(5'h05, 64'h0);
    wr(REG_EXTENDED_PAGE_CONTEXT, 64'hFFFF_FFFF_FFFF_FFFF);
    rd(REG_EXTENDED_PAGE_CONTEXT, 64'hFFFF_FFFC_0000_0000);
    $display("regs done");
  endtask
  task automatic t_watch();
    wr(REG_WATCH_LOW, 64'h0000_0000_0000_123A);
    wr(REG_WATCH_HIGH, 64'h0);
    mref(1'h1, 1'h0, 32'h0000_1238, 1'h1);
    mref(1'h0, 1'h1, 32'h0000_1238, 1'h0);
    mref(1'h1, 1'h0, 32'h0000_1240, 1'h0);
    wr(REG_WATCH_LOW, 64'h0000_0000_0000_1239);
    mref(1'h0, 1'h1, 32'h0000_123C, 1'h1);
    $display("watch done");
  endtask
  task automatic t_ctx();
    logic [1:0] sp [3] = '{SPACE_USER, SPACE_SUPER, SPACE_KERN};
    logic [63:0] va;
    foreach (sp[i]) begin
      va = {sp[i], 22'h2A_AAAA, 29'h0BAD_CAF0 + 29'(i), 11'h7FF};
      commit(EXC_TLB_MISS, va, 4'h0);
      chk(bad_virtual_address, va);
      rd(REG_EXTENDED_PAGE_CONTEXT, {30'h3FFF_FFFF, va[63:62], va[39:11], 3'h0});
    end
    $display("ctx done");
  endtask
  task automatic t_epc();
    ep(4'h8, 64'h8000_0100, 1'h1);
    ep(4'h6, 64'h8000_0104, 1'h0);
    ep(4'h9, 64'h8000_0104, 1'h0);
    $display("epc done");
  endtask
  task automatic t_epc16();
    ep(4'h6, 64'h8000_0101, 1'h1);
    ep(4'h2, 64'h8000_0105, 1'h0);
    ep(4'h8, 64'h8000_0100, 1'h1);
    $display("epc16 done");
  endtask
  task automatic t_tlb();
    @(negedge ref_clk);
    {tlb_wr, tlb_wr_idx, tlb_wr_payload} = {1'h1, 5'h1F, 32'hCAFE_F00D};
    tlb_wr_vaddr = 64'hC000_0000_0012_3800;
    @(negedge ref_clk);
    tlb_wr = 1'h0;
    look(MODE_KERNEL, 64'hC000_0000_0012_3C00, 2'h1);
    chk(tlb_payload, 64'hCAFE_F00D);
    look(MODE_USER, 64'hC000_0000_0012_3800, 2'h2);
    look(MODE_KERNEL, 64'hC000_0000_0045_6800, 2'h0);
    addr64_mode = 1'h0;
    look(MODE_KERNEL, 64'h8012_3800, 2'h0);
    $display("tlb done");
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    do_reset(1'h0);
    t_regs();
    t_watch();
    t_ctx();
    t_epc();
    do_reset(1'h1);
    t_epc16();
    t_tlb();
    test_done();
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    errors++;
    test_done();
  end
endmodule
bind sysctl_error_debug_regs error_debug_monitor u_mon (.ref_clk, .rst_n, .ce, .mem_valid,
  .mem_load, .mem_store, .watch_exception, .exc_commit, .exc_kind, .exc_vaddr,
  .exc_in_delay_slot, .error_level_flag, .branch_delay_flag, .bad_virtual_address,
  .cop_rd_num, .cop_rd_data, .tlb_hit, .address_error);
`default_nettype wire
